//--- design/flag_and_move_instruction_exec.sv
// execution of flag set/clear, register moves and post-increment loads
// Function
// - set sign flag, others kept, one cycle
// - clear sign flag, others kept, one cycle
// - set half carry, others kept, one cycle
// - clear half carry, others kept, one cycle
// - copy register to register, one cycle
// - copy register pair, one cycle, flags kept
// - load via pointer, then increment, two cycles
`timescale 1ns/100ps
module flag_and_move_instruction_exec (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire flag_move_pkg::op_t op,
  input wire logic [4:0] dst_idx,
  input wire logic [4:0] src_idx,
  input wire logic [4:0] ptr_idx,
  input wire logic [7:0] mem_rdata,
  output logic busy,
  output logic done,
  output logic mem_rd,
  output logic [15:0] mem_addr,
  output logic [7:0] status_flags_reg,
  output logic [255:0] reg_file_flat
);
  typedef enum logic [0:0] {st_idle, st_load} state_t;
  state_t state;
  logic [7:0] regs [0:flag_move_pkg::num_regs-1];
  logic [4:0] load_dst;
  logic [4:0] load_ptr;
  logic [4:0] load_ptr_hi;
  logic [15:0] ptr_value;
  logic [15:0] ptr_next;
  logic [7:0] next_status_flags_reg;
  logic take;
  logic take_set_sign;
  logic take_clear_sign;
  logic take_set_half;
  logic take_clear_half;
  logic take_copy;
  logic take_pair_copy;
  logic take_load;
  logic take_single;
  logic in_load;
  logic [4:0] dst_pair_lo;
  logic [4:0] dst_pair_hi;
  logic [4:0] src_pair_lo;
  logic [4:0] src_pair_hi;
  logic [4:0] ptr_pair_lo;
  logic [4:0] ptr_pair_hi;

  ////////////////////////////////////////////////////////////////////////
  // sizes that the flat view, the pair indexing and the pointer adder rely on
  if (flag_move_pkg::num_regs != (1 << flag_move_pkg::reg_idx_w)) begin : g_regs_check
    $error("register count must fill the index range");
  end
  if (flag_move_pkg::addr_w != 2 * flag_move_pkg::data_w) begin : g_ptr_check
    $error("pointer must be exactly one register pair wide");
  end
  if ($bits(reg_file_flat) != flag_move_pkg::num_regs * flag_move_pkg::data_w) begin : g_flat_check
    $error("flat register view width does not match the file");
  end

  ////////////////////////////////////////////////////////////////////////
  // request decode; nothing is taken while a load waits for memory
  assign take = op_valid && (state == st_idle);
  assign in_load = (state == st_load);
  assign take_set_sign = take && (op == flag_move_pkg::set_sign_flag_op);
  assign take_clear_sign = take && (op == flag_move_pkg::clear_sign_flag_op);
  assign take_set_half = take && (op == flag_move_pkg::set_half_carry_op);
  assign take_clear_half = take && (op == flag_move_pkg::clear_half_carry_op);
  assign take_copy = take && (op == flag_move_pkg::reg_copy_op);
  assign take_pair_copy = take && (op == flag_move_pkg::reg_pair_copy_op);
  assign take_load = take && (op == flag_move_pkg::indirect_load_op);
  // the empty code is accepted but does nothing, so it raises no done
  assign take_single = take && (op != flag_move_pkg::op_none) && !take_load;

  ////////////////////////////////////////////////////////////////////////
  // operand pairs: the even register is always the low byte
  assign dst_pair_lo = {dst_idx[4:1], 1'b0};
  assign dst_pair_hi = {dst_idx[4:1], 1'b1};
  assign src_pair_lo = {src_idx[4:1], 1'b0};
  assign src_pair_hi = {src_idx[4:1], 1'b1};
  assign ptr_pair_lo = {ptr_idx[4:1], 1'b0};
  assign ptr_pair_hi = {ptr_idx[4:1], 1'b1};
  assign load_ptr_hi = {load_ptr[4:1], 1'b1};
  assign ptr_value = {regs[load_ptr_hi], regs[load_ptr]};

  pointer_incrementer #(.width(flag_move_pkg::addr_w)) u_inc (
    .ptr_in(ptr_value),
    .ptr_out(ptr_next)
  );

  ////////////////////////////////////////////////////////////////////////
  // status flags: only the addressed bit changes
  always_comb begin
    next_status_flags_reg = status_flags_reg;
    if (take_set_sign) begin
      next_status_flags_reg[flag_move_pkg::flag_sign] = 1'b1;
    end
    if (take_clear_sign) begin
      next_status_flags_reg[flag_move_pkg::flag_sign] = 1'b0;
    end
    if (take_set_half) begin
      next_status_flags_reg[flag_move_pkg::flag_half_carry] = 1'b1;
    end
    if (take_clear_half) begin
      next_status_flags_reg[flag_move_pkg::flag_half_carry] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_flags_reg <= flag_move_pkg::status_reset;
    end else begin
      status_flags_reg <= next_status_flags_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencing: a load holds the core a second cycle while memory answers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= st_idle;
    end else begin
      unique case (state)
        st_idle: begin
          if (take_load) begin
            state <= st_load;
          end
        end
        st_load: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // busy marks the second load cycle; requests made then are ignored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else begin
      busy <= take_load;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // load targets are kept so the write does not depend on held inputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      load_dst <= 5'h00;
      load_ptr <= 5'h00;
    end else if (take_load) begin
      load_dst <= dst_idx;
      load_ptr <= ptr_pair_lo;
    end
  end

  // the address goes out together with the read strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_addr <= 16'h0000;
    end else if (take_load) begin
      mem_addr <= {regs[ptr_pair_hi], regs[ptr_pair_lo]};
    end
  end

  // strobes last one cycle each
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_rd <= 1'b0;
    end else begin
      mem_rd <= take_load;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done <= 1'b0;
    end else begin
      done <= take_single || in_load;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register file; moves never touch the flags
  // pointer update is written after the data so an aliased destination
  // loses to the pointer, a hazard software must avoid
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < flag_move_pkg::num_regs; i++) begin
        regs[i] <= flag_move_pkg::data_reset;
      end
    end else if (in_load) begin
      regs[load_dst] <= mem_rdata;
      regs[load_ptr] <= ptr_next[7:0];
      regs[load_ptr_hi] <= ptr_next[15:8];
    end else if (take_copy) begin
      regs[dst_idx] <= regs[src_idx];
    end else if (take_pair_copy) begin
      regs[dst_pair_lo] <= regs[src_pair_lo];
      regs[dst_pair_hi] <= regs[src_pair_hi];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flat view for the ports, one cycle behind the file
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_file_flat <= '0;
    end else begin
      for (int i = 0; i < flag_move_pkg::num_regs; i++) begin
        reg_file_flat[i*flag_move_pkg::data_w +: flag_move_pkg::data_w] <= regs[i];
      end
    end
  end
endmodule : flag_and_move_instruction_exec

//--- design/pointer_incrementer.sv
// full-width pointer post-increment adder
`timescale 1ns/100ps
module pointer_incrementer #(
  parameter int width = 16
) (
  input wire logic [width-1:0] ptr_in,
  output logic [width-1:0] ptr_out
);
  // a pointer narrower than two bits cannot span a register pair
  if (width < 2) begin : g_width_check
    $error("pointer width too small");
  end
  // one adder over the whole pair so the low byte carries into the high byte
  assign ptr_out = ptr_in + width'(flag_move_pkg::pointer_step);
endmodule : pointer_incrementer

//--- pkg/flag_move_pkg.sv
// constants shared by the flag and move execution block
package flag_move_pkg;
  localparam int data_w = 8;
  localparam int addr_w = 16;
  localparam int reg_idx_w = 5;
  localparam int num_regs = 32;
  // status flag bit positions
  localparam int flag_half_carry = 5;
  localparam int flag_sign = 4;
  localparam logic [7:0] status_reset = 8'h00;
  localparam logic [7:0] data_reset = 8'h00;
  localparam logic [15:0] pointer_step = 16'h0001;
  // cycle counts per instruction
  localparam int flag_op_cycles = 1;
  localparam int move_op_cycles = 1;
  localparam int load_op_cycles = 2;
  typedef enum logic [2:0] {
    op_none,
    set_sign_flag_op,
    clear_sign_flag_op,
    set_half_carry_op,
    clear_half_carry_op,
    reg_copy_op,
    reg_pair_copy_op,
    indirect_load_op
  } op_t;
endpackage : flag_move_pkg

//--- verification/flag_move_checker.sv
// assertions on the flag and move block ports
`timescale 1ns/100ps
module flag_move_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire flag_move_pkg::op_t op,
  input wire logic [4:0] ptr_idx,
  input wire logic busy,
  input wire logic done,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] status_flags_reg,
  input wire logic [255:0] reg_file_flat
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence take(flag_move_pkg::op_t o);
    op_valid && !busy && op == o;
  endsequence
  // a load shows its read strobe first and finishes one cycle later
  sequence load_read_step;
    mem_rd && busy;
  endsequence
  sequence load_done_step;
    done && !busy && $stable(status_flags_reg);
  endsequence
  sign_set_a: assert property (take(flag_move_pkg::set_sign_flag_op) |=>
    status_flags_reg == ($past(status_flags_reg) | 8'h10)) else $error("sign set wrong");
  sign_clear_a: assert property (take(flag_move_pkg::clear_sign_flag_op) |=>
    status_flags_reg == ($past(status_flags_reg) & 8'hef)) else $error("sign clear wrong");
  half_set_a: assert property (take(flag_move_pkg::set_half_carry_op) |=>
    status_flags_reg == ($past(status_flags_reg) | 8'h20)) else $error("half set wrong");
  half_clear_a: assert property (take(flag_move_pkg::clear_half_carry_op) |=>
    status_flags_reg == ($past(status_flags_reg) & 8'hdf)) else $error("half clear wrong");
  copy_one_a: assert property (take(flag_move_pkg::reg_copy_op) |=>
    done && $stable(status_flags_reg)) else $error("copy not one cycle");
  pair_one_a: assert property (take(flag_move_pkg::reg_pair_copy_op) |=>
    done && $stable(status_flags_reg)) else $error("pair copy not one cycle");
  flag_done_a: assert property (op_valid && !busy &&
    op inside {flag_move_pkg::set_sign_flag_op, flag_move_pkg::clear_sign_flag_op,
    flag_move_pkg::set_half_carry_op, flag_move_pkg::clear_half_carry_op} |=> done)
    else $error("flag op not one cycle");
  load_two_a: assert property (take(flag_move_pkg::indirect_load_op) |=>
    load_read_step ##1 load_done_step) else $error("load timing");
  // the flat view shows the written pointer two edges after the strobe;
  // the pointer index is taken from the request edge, not the current one
  ptr_carry_a: assert property (mem_rd |-> ##2
    reg_file_flat[{$past(ptr_idx[4:1], 3), 4'h0} +: 16] == $past(mem_addr, 2) + 16'h0001)
    else $error("pointer step wrong");
endmodule : flag_move_checker
bind flag_and_move_instruction_exec flag_move_checker chk_i (
  .clk(clk),
  .rst_b(rst_b),
  .op_valid(op_valid),
  .op(op),
  .ptr_idx(ptr_idx),
  .busy(busy),
  .done(done),
  .mem_rd(mem_rd),
  .mem_addr(mem_addr),
  .status_flags_reg(status_flags_reg),
  .reg_file_flat(reg_file_flat)
);

//--- verification/tb.sv
// self-checking bench for the flag and move block
`timescale 1ns/100ps
module tb;
  logic clk = 1'h0, rst_b = 1'h0, op_valid = 1'h0, busy, done, mem_rd;
  flag_move_pkg::op_t op = flag_move_pkg::op_none;
  logic [4:0] dst_idx = 5'h00, src_idx = 5'h00, ptr_idx = 5'h1e;
  logic [7:0] mem_rdata = 8'h00, status_flags_reg;
  logic [15:0] mem_addr, seen;
  logic [255:0] reg_file_flat;
  int fails = 0, checks = 0;
  always #12.5 clk = ~clk;
  flag_and_move_instruction_exec dut (
    .clk(clk),
    .rst_b(rst_b),
    .op_valid(op_valid),
    .op(op),
    .dst_idx(dst_idx),
    .src_idx(src_idx),
    .ptr_idx(ptr_idx),
    .mem_rdata(mem_rdata),
    .busy(busy),
    .done(done),
    .mem_rd(mem_rd),
    .mem_addr(mem_addr),
    .status_flags_reg(status_flags_reg),
    .reg_file_flat(reg_file_flat)
  );
  task report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task chk_flags(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_flags
  // src and pointer share one index; reg file lags done by a cycle
  task run(input flag_move_pkg::op_t o, input logic [4:0] d, p, input logic [7:0] m);
    int i;
    // a load that never strobes must not pass on an older address
    seen = 16'hffff;
    @(negedge clk);
    op = o;
    dst_idx = d;
    src_idx = p;
    ptr_idx = p;
    mem_rdata = m;
    op_valid = 1'h1;
    @(negedge clk);
    op_valid = 1'h0;
    for (i = 0; i < 4 && done !== 1'h1; i++) begin
      if (mem_rd === 1'h1) seen = mem_addr;
      @(negedge clk);
    end
    if (i == 4) begin
      fails++;
      report_and_stop();
    end
    @(negedge clk);
  endtask : run
  // each flag op alone, so a stray write to the neighbour bit shows
  task flag_scenario;
    run(flag_move_pkg::set_sign_flag_op, 5'h00, 5'h00, 8'h00);
    chk_flags(status_flags_reg, 8'h10);
    run(flag_move_pkg::set_half_carry_op, 5'h00, 5'h00, 8'h00);
    chk_flags(status_flags_reg, 8'h30);
    run(flag_move_pkg::clear_sign_flag_op, 5'h00, 5'h00, 8'h00);
    chk_flags(status_flags_reg, 8'h20);
    run(flag_move_pkg::clear_half_carry_op, 5'h00, 5'h00, 8'h00);
    chk_flags(status_flags_reg, 8'h00);
    run(flag_move_pkg::set_sign_flag_op, 5'h00, 5'h00, 8'h00);
    chk_flags(status_flags_reg, 8'h10);
  endtask : flag_scenario
  // the second load leaves ff in a low pointer byte, so the third must carry
  task load_scenario;
    run(flag_move_pkg::indirect_load_op, 5'h01, 5'h1e, 8'ha5);
    chk(seen, 16'h0000);
    chk(reg_file_flat[240 +: 16], 16'h0001);
    run(flag_move_pkg::indirect_load_op, 5'h1e, 5'h1c, 8'hff);
    chk(reg_file_flat[224 +: 16], 16'h0001);
    run(flag_move_pkg::indirect_load_op, 5'h02, 5'h1e, 8'h3c);
    chk(seen, 16'h00ff);
    chk(reg_file_flat[240 +: 16], 16'h0100);
    chk(reg_file_flat[8 +: 16], 16'h3ca5);
    chk_flags(status_flags_reg, 8'h10);
  endtask : load_scenario
  task move_scenario;
    run(flag_move_pkg::reg_copy_op, 5'h03, 5'h01, 8'h00);
    chk(reg_file_flat[24 +: 16], 16'h00a5);
    chk_flags(status_flags_reg, 8'h10);
    run(flag_move_pkg::reg_pair_copy_op, 5'h04, 5'h1e, 8'h00);
    chk(reg_file_flat[32 +: 16], 16'h0100);
    chk_flags(status_flags_reg, 8'h10);
  endtask : move_scenario
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'h1;
    flag_scenario();
    load_scenario();
    move_scenario();
    report_and_stop();
  end
endmodule : tb
